/* File: rtl/alu_shift_sub_table.v */
// Execution slice: rotate, extend, shifts, accumulator shift, subtract with borrow, table access.
// Assumes the decoder supplies resolved operands and destination selects; the core writes back o_result.
`timescale 1ns/1ns
`include "alu_ops_defines.vh"

// Behaviour
// - Rotate right without carry, one cycle, updates negative and zero only.
// - File source with working destination writes working register, file untouched.
// - Sign extend copies bit 7 into upper byte; one cycle; C, N, Z updated.
// - Zero extend clears upper byte; one cycle; C, Z, N updated.
// - Shift left by working-register count; only N and Z updated.
// - Shift left by 5-bit literal; one cycle; only N and Z updated.
// - Accumulator arithmetic shift by signed register count; update accumulator OV/SAT flags.
// - Accumulator shift by signed 6-bit literal; one cycle; same flag updates.
// - Subtract with borrow: base minus source minus inverted carry; five flags.
// - File form: file minus working register minus borrow, written to file.
// - 10-bit literal form: register minus literal minus borrow, in place, one cycle.
// - Reverse form: source minus base minus borrow; same five flags.
// - Reverse literal form: literal minus base minus borrow.
// - Table read high puts word bits 23:16 in low byte; two cycles; no flags.
// - Table read low puts word bits 15:0 in destination; two cycles; no flags.
// - Table write high writes source low byte to bits 23:16; two cycles.
// - Table write low writes full source to bits 15:0; two cycles.
module alu_shift_sub_table
(
   input wire i_sys_clk,
   input wire i_rstn,
   input wire i_start,
   input wire [3:0] i_op,
   input wire [15:0] i_base,
   input wire [15:0] i_source,
   input wire [15:0] i_literal,
   input wire i_acc_sel,
   input wire i_to_working,
   input wire [23:0] i_prog_rdata,
   output wire o_busy,
   output reg o_done,
   output reg [15:0] o_result,
   output reg o_result_we,
   output reg o_result_to_working,
   output reg o_result_byte,
   output reg o_prog_re,
   output reg o_prog_we,
   output reg [23:0] o_prog_wdata,
   output reg [23:0] o_prog_wmask,
   output wire [15:0] o_status,
   output wire [39:0] o_acc_a,
   output wire [39:0] o_acc_b
);

   localparam ST_IDLE = 1'b0;
   localparam ST_TABLE = 1'b1;

   reg state;
   reg [3:0] table_op;
   reg [15:0] table_src;
   reg [15:0] status;
   reg [39:0] acc_a;
   reg [39:0] acc_b;
   reg [15:0] next_status;
   reg [15:0] next_result;
   reg next_we;
   reg [39:0] next_acc;
   reg next_acc_we;
   reg [5:0] shamt;
   reg [16:0] diff;
   reg [4:0] diff_lo;
   reg [15:0] minuend;
   reg [15:0] subtrahend;
   reg [79:0] wide;
   reg [39:0] sel_acc;
   reg sat_hit;
   reg ovf_hit;

   // Sets N and Z from a 16-bit result, other bits untouched
   function [15:0] set_nz;
      input [15:0] st;
      input [15:0] res;
      begin
         set_nz = st;
         set_nz[`FLAG_N] = res[15];
         set_nz[`FLAG_Z] = (res == 16'h0000);
      end
   endfunction

   // True when a 40-bit accumulator value no longer fits a signed 32-bit word
   function beyond_32;
      input [39:0] value;
      begin
         beyond_32 = (value[39:31] != {9{value[31]}});
      end
   endfunction

   assign o_status = status;
   assign o_acc_a = acc_a;
   assign o_acc_b = acc_b;
   assign o_busy = (state == ST_TABLE);

   always @*
   begin
      next_status = status;
      next_result = 16'h0000;
      next_we = 1'b0;
      next_acc = 40'h0000000000;
      next_acc_we = 1'b0;
      shamt = 6'h00;
      diff = 17'h00000;
      diff_lo = 5'h00;
      minuend = i_base;
      subtrahend = i_source;
      wide = 80'h0;
      sel_acc = i_acc_sel ? acc_b : acc_a;
      sat_hit = 1'b0;
      ovf_hit = 1'b0;
      if (i_start && state == ST_IDLE)
      begin
         case (i_op)
            `OP_ROTATE_RIGHT_NO_CARRY:
            begin
               next_result = {i_source[0], i_source[15:1]};
               next_we = 1'b1;
               next_status = set_nz(status, next_result);
            end
            `OP_SIGN_EXTEND:
            begin
               next_result = {{8{i_source[7]}}, i_source[7:0]};
               next_we = 1'b1;
               next_status = set_nz(status, next_result);
               // Carry takes the inverse of N, as an extend of a positive byte never borrows
               next_status[`FLAG_C] = ~i_source[7];
            end
            `OP_ZERO_EXTEND:
            begin
               next_result = {8'h00, i_source[7:0]};
               next_we = 1'b1;
               next_status = set_nz(status, next_result);
               next_status[`FLAG_C] = 1'b1;
            end
            `OP_SHIFT_LEFT_REG, `OP_SHIFT_LEFT_LIT:
            begin
               // Counts of 16 to 31 clear the word; only low 5 count bits are used, so higher counts wrap
               shamt = {1'b0, i_op == `OP_SHIFT_LEFT_REG ? i_source[4:0] : i_literal[4:0]};
               next_result = (shamt[4]) ? 16'h0000 : (i_base << shamt[3:0]);
               next_we = 1'b1;
               next_status = set_nz(status, next_result);
            end
            `OP_ACCUMULATOR_SHIFT_REG, `OP_ACCUMULATOR_SHIFT_LIT:
            begin
               shamt = (i_op == `OP_ACCUMULATOR_SHIFT_REG) ? i_source[5:0] : i_literal[5:0];
               // Positive count shifts right, negative shifts left; magnitude up to 31 right and 32 left
               if (!shamt[5])
                  next_acc = $signed(sel_acc) >>> shamt[4:0];
               else
               begin
                  wide = {{40{sel_acc[39]}}, sel_acc} << (6'h00 - shamt);
                  next_acc = wide[39:0];
                  ovf_hit = (wide[79:31] != {49{wide[31]}});
                  sat_hit = (wide[79:39] != {41{wide[39]}});
               end
               next_acc_we = 1'b1;
               if (!shamt[5])
                  ovf_hit = beyond_32(next_acc);
               // Saturation flags are sticky; only reset clears them and no clamping is applied
               // The idle accumulator's overflow flag is refreshed from the value it holds
               if (i_acc_sel)
               begin
                  next_status[`FLAG_ACCUM_B_OV] = ovf_hit;
                  next_status[`FLAG_ACCUM_B_SAT] = status[`FLAG_ACCUM_B_SAT] | sat_hit;
                  next_status[`FLAG_ACCUM_A_OV] = beyond_32(acc_a);
               end
               else
               begin
                  next_status[`FLAG_ACCUM_A_OV] = ovf_hit;
                  next_status[`FLAG_ACCUM_A_SAT] = status[`FLAG_ACCUM_A_SAT] | sat_hit;
                  next_status[`FLAG_ACCUM_B_OV] = beyond_32(acc_b);
               end
               next_status[`FLAG_COMBINED_OV] = next_status[`FLAG_ACCUM_A_OV] | next_status[`FLAG_ACCUM_B_OV];
               next_status[`FLAG_COMBINED_SAT] = next_status[`FLAG_ACCUM_A_SAT] | next_status[`FLAG_ACCUM_B_SAT];
            end
            `OP_ACCUMULATOR_LOAD:
            begin
               // Core fills an accumulator here; otherwise the shift paths only ever see zero
               // No flags move, and no register write is requested
               next_acc = {i_literal[7:0], i_base, i_source};
               next_acc_we = 1'b1;
            end
            `OP_SUBTRACT_WITH_BORROW, `OP_REVERSE_SUBTRACT_WITH_BORROW:
            begin
               // Decoder places file reg or literal in i_source as the operand form requires
               if (i_op == `OP_SUBTRACT_WITH_BORROW)
               begin
                  minuend = i_base;
                  subtrahend = i_source;
               end
               else
               begin
                  minuend = i_source;
                  subtrahend = i_base;
               end
               diff = {1'b0, minuend} + {1'b0, ~subtrahend} + {16'h0000, status[`FLAG_C]};
               diff_lo = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, status[`FLAG_C]};
               next_result = diff[15:0];
               next_we = 1'b1;
               next_status = set_nz(status, next_result);
               next_status[`FLAG_C] = diff[16];
               next_status[`FLAG_DC] = diff_lo[4];
               next_status[`FLAG_OV] = (minuend[15] != subtrahend[15]) && (diff[15] != minuend[15]);
            end
            default:
            begin
               next_we = 1'b0;
            end
         endcase
      end
   end

   always @(posedge i_sys_clk)
   begin
      if (!i_rstn)
      begin
         state <= ST_IDLE;
         table_op <= `OP_NONE;
         table_src <= 16'h0000;
         status <= `STATUS_RESET;
         acc_a <= `ACC_RESET;
         acc_b <= `ACC_RESET;
         o_done <= 1'b0;
         o_result <= 16'h0000;
         o_result_we <= 1'b0;
         o_result_to_working <= 1'b0;
         o_result_byte <= 1'b0;
         o_prog_re <= 1'b0;
         o_prog_we <= 1'b0;
         o_prog_wdata <= 24'h000000;
         o_prog_wmask <= 24'h000000;
      end
      else
      begin
         o_done <= 1'b0;
         o_result_we <= 1'b0;
         o_prog_re <= 1'b0;
         o_prog_we <= 1'b0;
         o_result_byte <= 1'b0;
         case (state)
            ST_IDLE:
            begin
               status <= next_status;
               // Only the selected accumulator is written
               if (next_acc_we && i_acc_sel)
                  acc_b <= next_acc;
               else if (next_acc_we)
                  acc_a <= next_acc;
               if (i_start)
               begin
                  if (i_op >= `OP_TABLE_READ_HIGH && i_op <= `OP_TABLE_WRITE_LOW)
                  begin
                     // Table access spends a first cycle on the program memory port
                     state <= ST_TABLE;
                     table_op <= i_op;
                     table_src <= i_source;
                     o_prog_re <= (i_op == `OP_TABLE_READ_HIGH) || (i_op == `OP_TABLE_READ_LOW);
                     o_prog_we <= (i_op == `OP_TABLE_WRITE_HIGH) || (i_op == `OP_TABLE_WRITE_LOW);
                     o_prog_wdata <= {i_source[7:0], i_source};
                     o_prog_wmask <= (i_op == `OP_TABLE_WRITE_HIGH) ? 24'hff0000 : 24'h00ffff;
                  end
                  else
                  begin
                     o_done <= 1'b1;
                     o_result <= next_result;
                     o_result_we <= next_we;
                     o_result_to_working <= i_to_working;
                  end
               end
            end
            ST_TABLE:
            begin
               // Second cycle: read data returns; status is not touched
               state <= ST_IDLE;
               o_done <= 1'b1;
               o_result_to_working <= 1'b0;
               if (table_op == `OP_TABLE_READ_HIGH)
               begin
                  o_result <= {8'h00, i_prog_rdata[23:16]};
                  o_result_byte <= 1'b1;
                  o_result_we <= 1'b1;
               end
               else if (table_op == `OP_TABLE_READ_LOW)
               begin
                  o_result <= i_prog_rdata[15:0];
                  o_result_we <= 1'b1;
               end
               else
                  o_result <= table_src;
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

endmodule // alu_shift_sub_table

/* File: rtl/alu_ops_defines.vh */
// Constants for the shift, subtract-with-borrow and table-access execution slice.
// Assumes a 16-bit data path and 24-bit program memory words.
`ifndef ALU_OPS_DEFINES_VH
`define ALU_OPS_DEFINES_VH

// Operation codes from the decoder
`define OP_NONE 4'h0
`define OP_ROTATE_RIGHT_NO_CARRY 4'h1
`define OP_SIGN_EXTEND 4'h2
`define OP_ZERO_EXTEND 4'h3
`define OP_SHIFT_LEFT_REG 4'h4
`define OP_SHIFT_LEFT_LIT 4'h5
`define OP_ACCUMULATOR_SHIFT_REG 4'h6
`define OP_ACCUMULATOR_SHIFT_LIT 4'h7
`define OP_SUBTRACT_WITH_BORROW 4'h8
`define OP_REVERSE_SUBTRACT_WITH_BORROW 4'h9
`define OP_TABLE_READ_HIGH 4'ha
`define OP_TABLE_READ_LOW 4'hb
`define OP_TABLE_WRITE_HIGH 4'hc
`define OP_TABLE_WRITE_LOW 4'hd
`define OP_ACCUMULATOR_LOAD 4'he

// Status word bit positions
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_OV 2
`define FLAG_N 3
`define FLAG_DC 8
`define FLAG_COMBINED_SAT 10
`define FLAG_COMBINED_OV 11
`define FLAG_ACCUM_B_SAT 12
`define FLAG_ACCUM_A_SAT 13
`define FLAG_ACCUM_B_OV 14
`define FLAG_ACCUM_A_OV 15

`define STATUS_RESET 16'h0000
`define ACC_RESET 40'h0000000000
`define TABLE_CYCLES 2'h2
`define SINGLE_CYCLES 2'h1

`endif

/* File: tb/prog_word_model.sv */
// Program memory model: a single addressed 24-bit word.
// Assumes the core supplies the address; only the strobes, write data and write mask reach here.
`timescale 1ns/1ns
module prog_word_model
#(
   parameter [23:0] INIT = 24'h5a3c96
)
(
   input wire i_sys_clk,
   input wire i_prog_re,
   input wire i_prog_we,
   input wire [23:0] i_prog_wdata,
   input wire [23:0] i_prog_wmask,
   output wire [23:0] o_prog_rdata
);
   reg [23:0] word = INIT;
   // Inverted outside the read strobe so stale data never matches
   assign o_prog_rdata = i_prog_re ? word : ~word;
   always @(posedge i_sys_clk)
   begin
      if (i_prog_we)
      begin
         word <= (word & ~i_prog_wmask) | (i_prog_wdata & i_prog_wmask);
      end
   end
endmodule // prog_word_model

/* File: tb/alu_shift_sub_table_sva.sv */
// Checker for the execution slice: results, table timing, flag holding.
// Assumes binding to alu_shift_sub_table; sees only its ports.
`timescale 1ns/1ns
`include "alu_ops_defines.vh"
module alu_shift_sub_table_sva
(
   input wire i_sys_clk,
   input wire i_rstn,
   input wire i_start,
   input wire [3:0] i_op,
   input wire [15:0] i_base,
   input wire [15:0] i_source,
   input wire i_to_working,
   input wire [23:0] i_prog_rdata,
   input wire o_busy,
   input wire o_done,
   input wire [15:0] o_result,
   input wire o_result_we,
   input wire o_result_to_working,
   input wire o_result_byte,
   input wire o_prog_re,
   input wire o_prog_we,
   input wire [23:0] o_prog_wdata,
   input wire [23:0] o_prog_wmask,
   input wire [15:0] o_status
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rstn);
   wire take = i_start && !o_busy;
   rotate_result_a: assert property (take && i_op == `OP_ROTATE_RIGHT_NO_CARRY
      |=> o_done && o_result == {$past(i_source[0]), $past(i_source[15:1])}) else $error("rotate result wrong");
   working_dest_a: assert property (take && i_op == `OP_ROTATE_RIGHT_NO_CARRY
      |=> o_result_we && o_result_to_working == $past(i_to_working)) else $error("destination select wrong");
   sign_fill_a: assert property (take && i_op == `OP_SIGN_EXTEND
      |=> o_result == {{8{$past(i_source[7])}}, $past(i_source[7:0])}) else $error("sign extend wrong");
   zero_fill_a: assert property (take && i_op == `OP_ZERO_EXTEND
      |=> o_result == {8'h00, $past(i_source[7:0])}) else $error("zero extend wrong");
   borrow_sub_a: assert property (take && i_op == `OP_SUBTRACT_WITH_BORROW
      |=> o_result == $past(i_base) - $past(i_source) - {15'h0000, !$past(o_status[0])}) else $error("subtract wrong");
   read_high_a: assert property (take && i_op == `OP_TABLE_READ_HIGH
      |=> o_prog_re && o_busy ##1 o_done && o_result_byte && o_result[7:0] == $past(i_prog_rdata[23:16]))
      else $error("read high wrong");
   read_low_a: assert property (take && i_op == `OP_TABLE_READ_LOW
      |=> o_prog_re ##1 o_done && o_result_we && o_result == $past(i_prog_rdata[15:0])) else $error("read low wrong");
   write_high_a: assert property (take && i_op == `OP_TABLE_WRITE_HIGH
      |=> o_prog_we && o_prog_wmask == 24'hff0000 && o_prog_wdata[23:16] == $past(i_source[7:0]) ##1 o_done)
      else $error("write high wrong");
   write_low_a: assert property (take && i_op == `OP_TABLE_WRITE_LOW
      |=> o_prog_we && o_prog_wmask == 24'h00ffff && o_prog_wdata[15:0] == $past(i_source)) else $error("write low wrong");
   table_flags_a: assert property (take && i_op >= `OP_TABLE_READ_HIGH && i_op <= `OP_TABLE_WRITE_LOW
      |=> $stable(o_status) ##1 $stable(o_status)) else $error("table op changed status");
endmodule // alu_shift_sub_table_sva
bind alu_shift_sub_table alu_shift_sub_table_sva sva_i (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_start(i_start),
   .i_op(i_op), .i_base(i_base), .i_source(i_source), .i_to_working(i_to_working), .i_prog_rdata(i_prog_rdata),
   .o_busy(o_busy), .o_done(o_done), .o_result(o_result), .o_result_we(o_result_we),
   .o_result_to_working(o_result_to_working), .o_result_byte(o_result_byte), .o_prog_re(o_prog_re),
   .o_prog_we(o_prog_we), .o_prog_wdata(o_prog_wdata), .o_prog_wmask(o_prog_wmask), .o_status(o_status));

/* File: tb/cpu_alu_shift_subtract_table_ops_test.sv */
// Self-checking bench: every op code, then random ops, against a behavioural model.
// Assumes the slice, its defines header and the program word model.
`timescale 1ns/1ns
`include "alu_ops_defines.vh"
module cpu_alu_shift_subtract_table_ops_test;
   localparam [23:0] INIT = 24'h5a3c96;
   reg i_sys_clk = 0;
   reg i_rstn = 0;
   reg i_start = 0;
   reg [3:0] i_op = 4'h0;
   reg [15:0] i_base = 16'h0000;
   reg [15:0] i_source = 16'h0000;
   reg [15:0] i_literal = 16'h0000;
   reg i_acc_sel = 0;
   reg i_to_working = 0;
   wire [23:0] i_prog_rdata;
   wire o_busy, o_done, o_result_we, o_result_to_working, o_result_byte, o_prog_re, o_prog_we;
   wire [15:0] o_result, o_status;
   wire [23:0] o_prog_wdata, o_prog_wmask;
   wire [39:0] o_acc_a, o_acc_b;
   integer errors = 0;
   integer checks = 0;
   integer i;
   reg [15:0] lfsr = 16'h0038;
   reg [15:0] st = 16'h0000;
   reg [23:0] word = INIT;
   reg [39:0] acc_m [0:1];
   always #4 i_sys_clk = ~i_sys_clk;
   alu_shift_sub_table DUT (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_start(i_start), .i_op(i_op), .i_base(i_base),
      .i_source(i_source), .i_literal(i_literal), .i_acc_sel(i_acc_sel), .i_to_working(i_to_working),
      .i_prog_rdata(i_prog_rdata), .o_busy(o_busy), .o_done(o_done), .o_result(o_result), .o_result_we(o_result_we),
      .o_result_to_working(o_result_to_working), .o_result_byte(o_result_byte), .o_prog_re(o_prog_re),
      .o_prog_we(o_prog_we), .o_prog_wdata(o_prog_wdata), .o_prog_wmask(o_prog_wmask), .o_status(o_status),
      .o_acc_a(o_acc_a), .o_acc_b(o_acc_b));
   prog_word_model #(.INIT(INIT)) mem (.i_sys_clk(i_sys_clk), .i_prog_re(o_prog_re), .i_prog_we(o_prog_we),
      .i_prog_wdata(o_prog_wdata), .i_prog_wmask(o_prog_wmask), .o_prog_rdata(i_prog_rdata));
   function [15:0] rnd(input integer m);
      begin
         lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
         rnd = 16'(lfsr % m);
      end
   endfunction
   task complete_run;
      begin
         if (errors == 0 && checks > 0) $display("== PASSED ==");
         else $display("== FAILED ==");
         $finish;
      end
   endtask
   task chk(input [39:0] got, input [39:0] exp);
      begin
         checks = checks + 1;
         if (got !== exp)
         begin
            errors = errors + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask
   task go(input [3:0] op);
      reg [16:0] d;
      reg [4:0] dn;
      reg [15:0] a, b, r, mk;
      reg we;
      reg [5:0] c;
      reg signed [79:0] v;
      integer k;
      begin
         @(negedge i_sys_clk);
         i_op = op;
         i_base = rnd(65536);
         i_source = op == `OP_SHIFT_LEFT_REG ? rnd(20) : rnd(65536);
         i_literal = rnd(65536);
         i_acc_sel = i_base[0];
         i_to_working = i_base[1];
         i_start = 1;
         we = op != 0 && op < 4'h6 || op > 4'h7 && op < 4'hc;
         mk = 16'hffff;
         r = 16'h0000;
         {a, b} = op == `OP_REVERSE_SUBTRACT_WITH_BORROW ? {i_source, i_base} : {i_base, i_source};
         d = {1'b0, a} - b - !st[0];
         dn = {1'b0, a[3:0]} - b[3:0] - !st[0];
         case (op)
            `OP_ROTATE_RIGHT_NO_CARRY: r = {i_source[0], i_source[15:1]};
            `OP_SIGN_EXTEND: begin r = {{8{i_source[7]}}, i_source[7:0]}; st[0] = ~i_source[7]; end
            `OP_ZERO_EXTEND: begin r = {8'h00, i_source[7:0]}; st[0] = 1; end
            `OP_SHIFT_LEFT_REG: r = i_base << i_source;
            `OP_SHIFT_LEFT_LIT: r = i_base << i_literal[4:0];
            `OP_SUBTRACT_WITH_BORROW, `OP_REVERSE_SUBTRACT_WITH_BORROW:
            begin
               r = d[15:0];
               st[0] = ~d[16];
               st[8] = ~dn[4];
               st[2] = (a[15] ^ b[15]) & (r[15] ^ a[15]);
            end
            `OP_TABLE_READ_HIGH: begin r = {8'h00, word[23:16]}; mk = 16'h00ff; end
            `OP_TABLE_READ_LOW: r = word[15:0];
            `OP_TABLE_WRITE_HIGH: word[23:16] = i_source[7:0];
            `OP_TABLE_WRITE_LOW: word[15:0] = i_source;
            `OP_ACCUMULATOR_SHIFT_REG, `OP_ACCUMULATOR_SHIFT_LIT:
            begin
               c = op == `OP_ACCUMULATOR_SHIFT_REG ? i_source[5:0] : i_literal[5:0];
               v = $signed(acc_m[i_acc_sel]);
               // Negative count shifts left; range checks stand in for the flag rules
               if (c[5]) v = v <<< (6'h00 - c);
               else v = v >>> c;
               acc_m[i_acc_sel] = v[39:0];
               st[`FLAG_ACCUM_A_OV - i_acc_sel] = v > 80'sh7fffffff || v < -80'sh80000000;
               st[`FLAG_ACCUM_A_SAT - i_acc_sel] = st[`FLAG_ACCUM_A_SAT - i_acc_sel]
                  | (v > 80'sh7fffffffff || v < -80'sh8000000000);
               v = $signed(acc_m[~i_acc_sel]);
               st[`FLAG_ACCUM_B_OV + i_acc_sel] = v > 80'sh7fffffff || v < -80'sh80000000;
               st[`FLAG_COMBINED_OV] = st[`FLAG_ACCUM_A_OV] | st[`FLAG_ACCUM_B_OV];
               st[`FLAG_COMBINED_SAT] = st[`FLAG_ACCUM_A_SAT] | st[`FLAG_ACCUM_B_SAT];
            end
            `OP_ACCUMULATOR_LOAD: acc_m[i_acc_sel] = {i_literal[7:0], i_base, i_source};
            default: r = 16'h0000;
         endcase
         if (op != 0 && op < 4'h6 || op == 4'h8 || op == 4'h9)
         begin
            st[3] = r[15];
            st[1] = r == 16'h0000;
         end
         k = 0;
         do begin @(posedge i_sys_clk); #1; k = k + 1; end while (o_done !== 1'b1 && k < 4);
         if (o_done !== 1'b1)
         begin
            errors = errors + 1;
            complete_run;
         end
         chk(o_result_we, we);
         if (we) chk(o_result & mk, r & mk);
         if (we) chk(o_result_to_working, op < `OP_TABLE_READ_HIGH && i_to_working);
         chk(o_status, st);
         chk(o_result_byte, op == `OP_TABLE_READ_HIGH);
         chk(o_acc_a, acc_m[0]);
         chk(o_acc_b, acc_m[1]);
         chk(k, op > 4'h9 && op < 4'he ? 2 : 1);
         @(negedge i_sys_clk);
         i_start = 0;
      end
   endtask
   initial
   begin
      repeat (5) @(posedge i_sys_clk);
      @(negedge i_sys_clk);
      i_rstn = 1;
      chk(o_status, 0);
      acc_m[0] = 40'h0000000000;
      acc_m[1] = 40'h0000000000;
      for (i = 0; i < 200; i = i + 1) go(4'(i < 16 ? i : rnd(16)));
      chk(o_acc_a ^ o_acc_b, acc_m[0] ^ acc_m[1]);
      complete_run;
   end
endmodule // cpu_alu_shift_subtract_table_ops_test
